// *** uis_pkg.sv ***
// Purpose: shared constants and types for the uuid index selector
// Assumes: uuid list entries are 128 bits, list holds up to 127 entries
// Notes: invalid marker value is a parameter of the top module
package uis_pkg;
  localparam int UIS_UUID_W = 128;
  localparam int UIS_IDX_W = 7;
  localparam int UIS_DEPTH = 128;
  localparam int UIS_CMD_W = 8;
  localparam int UIS_NCMD = 256;
  localparam int UIS_REV_W = 8;
  localparam logic [UIS_UUID_W-1:0] UIS_ZERO_UUID = 128'h0;
  localparam logic [UIS_IDX_W-1:0] UIS_IDX_NONE = 7'h00;
  localparam logic [UIS_IDX_W-1:0] UIS_IDX_FIRST = 7'h01;
  localparam logic [UIS_IDX_W-1:0] UIS_IDX_LAST = 7'h7F;
  localparam int UIS_ATTR_UUID_LIST_BIT = 9;
  localparam logic [31:0] UIS_ATTR_RST = 32'h0000_0000;
  // command outcome codes
  typedef enum logic [1:0] {
    UIS_RES_DEFAULT = 2'b00,
    UIS_RES_SELECT = 2'b01,
    UIS_RES_ABORT = 2'b10
  } uis_res_e;
  // firmware activation states
  typedef enum logic [1:0] {
    UIS_FW_IDLE = 2'b00,
    UIS_FW_SCAN = 2'b01,
    UIS_FW_DONE = 2'b10
  } uis_fw_e;
endpackage : uis_pkg

// *** uis_entry_class.sv ***
// Purpose: classify one uuid list entry
// Assumes: inputs from same clock domain
// Notes: purely combinational
`timescale 1ns/1ps
module uis_entry_class
  import uis_pkg::*;
(
  input wire logic [UIS_UUID_W-1:0] entry, // list entry value
  input wire logic [UIS_UUID_W-1:0] invalid_marker, // withdrawn marker
  output logic is_zero, // entry empty
  output logic is_invalid, // entry withdrawn
  output logic is_valid // usable identifier
);
  // decode entry kind
  assign is_zero = (entry == UIS_ZERO_UUID);
  assign is_invalid = (entry == invalid_marker);
  assign is_valid = !is_zero && !is_invalid;
endmodule : uis_entry_class

// *** uis_fw_check.sv ***
// Purpose: decide whether new firmware list needs a reset
// Assumes: old and new entries presented by the caller, one per cycle
// Notes: major revision mismatch forces a reset without scanning
`timescale 1ns/1ps
module uis_fw_check
  import uis_pkg::*;
(
  input wire logic [UIS_UUID_W-1:0] old_entry, // current list entry
  input wire logic [UIS_UUID_W-1:0] new_entry, // downloaded list entry
  input wire logic [UIS_UUID_W-1:0] invalid_marker, // withdrawn marker
  output logic slot_conflict // non-empty slot gains a different valid id
);
  logic old_zero;
  logic old_valid;
  logic new_valid;

  uis_entry_class u_old (
    .entry(old_entry),
    .invalid_marker(invalid_marker),
    .is_zero(old_zero),
    .is_invalid(),
    .is_valid(old_valid)
  );
  uis_entry_class u_new (
    .entry(new_entry),
    .invalid_marker(invalid_marker),
    .is_zero(),
    .is_invalid(),
    .is_valid(new_valid)
  );
  // valid id over marker or other id; appending over zero and
  // withdrawing to the marker in place need no reset
  assign slot_conflict = new_valid && !old_zero &&
                         (!old_valid || (old_entry != new_entry));
endmodule : uis_fw_check

// *** uis_top.sv ***
// Purpose: uuid index selection for vendor specific command information
// Assumes: single clock mclk at 200 MHz, async active high reset rst
// Notes: list written by firmware port; commands decoded one per cycle
`timescale 1ns/1ps
// Notes on behaviour
// - list is consecutive non-zero entries ended by an all-zero entry
// - non-zero entries are either valid ids or the invalid marker
// - each command reports a selection-supported bit, one or zero
// - any supported command sets list-present flag; list readable
// - seven-bit index in bits 6:0 selects list entry when non-zero
// - zero index executes command with device-chosen default definition
// - non-zero index at valid id executes with that definition
// - abort when id unsupported, entry zero, or entry is marker
// - activation needs reset if valid id replaces marker or other id
// - every affected controller is reset on such activation
// - new ids should only be appended after existing entries
// - withdrawn ids become marker in place, others unmoved
// - marker never revived, list never shortened
// - reset decision may use major revision change instead of scan
module uis_top
  import uis_pkg::*;
#(
  // withdrawn marker, value is arbitrary
  parameter logic [UIS_UUID_W-1:0] INVALID_MARKER =
    128'h0000_0000_0000_0000_0000_0000_0000_0001
)
(
  input wire logic mclk, // controller clock
  input wire logic rst, // async reset, active high
  input wire logic list_wr, // firmware writes list entry
  input wire logic [UIS_IDX_W-1:0] list_wr_idx, // entry position
  input wire logic [UIS_UUID_W-1:0] list_wr_data, // entry value
  input wire logic sel_wr, // write selection-support bit
  input wire logic [UIS_CMD_W-1:0] sel_wr_cmd, // command opcode
  input wire logic sel_wr_en, // support bit value
  input wire logic sup_wr, // write per-entry support for a command
  input wire logic [UIS_IDX_W-1:0] sup_wr_idx, // entry position
  input wire logic [UIS_NCMD-1:0] sup_wr_mask, // commands supporting id
  input wire logic cmd_valid, // command presented
  input wire logic [UIS_CMD_W-1:0] cmd_op, // command opcode
  input wire logic [31:0] cmd_dw, // dword carrying index field
  input wire logic rd_req, // read list entry
  input wire logic [UIS_IDX_W-1:0] rd_idx, // entry to read
  input wire logic fw_start, // start activation check
  input wire logic [UIS_REV_W-1:0] fw_major_old, // running major rev
  input wire logic [UIS_REV_W-1:0] fw_major_new, // downloaded major rev
  input wire logic [UIS_UUID_W-1:0] fw_new_entry, // new list entry
  output logic res_valid, // outcome pulse
  output logic [1:0] res_kind, // uis_res_e outcome
  output logic [UIS_IDX_W-1:0] res_idx, // selected entry
  output logic [UIS_UUID_W-1:0] res_uuid, // selected identifier
  output logic res_sel_sup, // command supports selection
  output logic [31:0] controller_attribute_flags, // attribute flags
  output logic rd_valid, // read data pulse
  output logic [UIS_UUID_W-1:0] rd_data, // list entry read
  output logic [UIS_IDX_W-1:0] fw_scan_idx, // entry wanted from image
  output logic fw_done, // activation check finished
  output logic fw_reset_req // reset needed to activate
);
  // list storage and per-entry command support
  logic [UIS_UUID_W-1:0] list_mem [UIS_DEPTH];
  logic [UIS_NCMD-1:0] sup_mem [UIS_DEPTH];
  logic [UIS_NCMD-1:0] sel_sup_reg;
  logic [UIS_DEPTH-1:0] term_seen;
  logic res_valid_reg;
  logic [1:0] res_kind_reg;
  logic [UIS_IDX_W-1:0] res_idx_reg;
  logic [UIS_UUID_W-1:0] res_uuid_reg;
  logic res_sel_reg;
  logic [31:0] attr_reg;
  logic rd_valid_reg;
  logic [UIS_UUID_W-1:0] rd_data_reg;
  uis_fw_e fw_state_reg;
  uis_fw_e fw_state_next;
  logic [UIS_IDX_W-1:0] fw_idx_reg;
  logic fw_done_reg;
  logic fw_reset_reg;

  // index decode and entry lookup
  wire [UIS_IDX_W-1:0] idx = cmd_dw[UIS_IDX_W-1:0];
  wire idx_none = (idx == UIS_IDX_NONE);
  wire [UIS_UUID_W-1:0] ent = list_mem[idx];
  wire cmd_sel = sel_sup_reg[cmd_op];
  wire ent_sup = sup_mem[idx][cmd_op];
  wire past_end = term_seen[idx];
  wire ent_valid;

  uis_entry_class u_cls (
    .entry(ent),
    .invalid_marker(INVALID_MARKER),
    .is_zero(),
    .is_invalid(),
    .is_valid(ent_valid)
  );

  // outcome selection
  wire use_default = !cmd_sel || idx_none;
  wire do_select = ent_valid && ent_sup && !past_end;
  wire [1:0] kind_w = use_default ? UIS_RES_DEFAULT :
                      do_select ? UIS_RES_SELECT :
                      UIS_RES_ABORT;

  // terminator scan: entry i lies past end if any entry from 1 to i-1 is zero
  wire [UIS_DEPTH-1:0] zero_vec;
  genvar g;
  generate
    for (g = 0; g < UIS_DEPTH; g++) begin : g_zero
      assign zero_vec[g] = (list_mem[g] == UIS_ZERO_UUID);
    end
    for (g = 0; g < UIS_DEPTH; g++) begin : g_term
      if (g < 2) begin : g_lo
        assign term_seen[g] = 1'b0;
      end else begin : g_hi
        // entry 0 unused; list starts at index 1
        assign term_seen[g] = |zero_vec[g-1:1];
      end
    end
  endgenerate

  // firmware activation comparison
  wire fw_conflict;
  uis_fw_check u_fw (
    .old_entry(list_mem[fw_idx_reg]),
    .new_entry(fw_new_entry),
    .invalid_marker(INVALID_MARKER),
    .slot_conflict(fw_conflict)
  );
  wire major_diff = (fw_major_old != fw_major_new);
  wire fw_last = (fw_idx_reg == UIS_IDX_LAST);

  // activation state machine
  always_comb begin
    fw_state_next = fw_state_reg;
    case (fw_state_reg)
      UIS_FW_IDLE: begin
        if (fw_start) begin
          fw_state_next = major_diff ? UIS_FW_DONE : UIS_FW_SCAN;
        end
      end
      UIS_FW_SCAN: begin
        if (fw_last || fw_reset_reg) begin
          fw_state_next = UIS_FW_DONE;
        end
      end
      UIS_FW_DONE: begin
        fw_state_next = UIS_FW_IDLE;
      end
      default: begin
        fw_state_next = UIS_FW_IDLE;
      end
    endcase
  end

  // list and support memories, no reset
  always_ff @(posedge mclk) begin
    if (list_wr) begin
      list_mem[list_wr_idx] <= list_wr_data;
    end
    if (sup_wr) begin
      sup_mem[sup_wr_idx] <= sup_wr_mask;
    end
  end

  // selection-support bits and attribute flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_sup_reg <= '0;
      attr_reg <= UIS_ATTR_RST;
    end else begin
      if (sel_wr) begin
        sel_sup_reg[sel_wr_cmd] <= sel_wr_en;
      end
      attr_reg[UIS_ATTR_UUID_LIST_BIT] <= |sel_sup_reg;
    end
  end

  // command outcome registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res_valid_reg <= 1'b0;
      res_kind_reg <= UIS_RES_DEFAULT;
      res_idx_reg <= '0;
      res_uuid_reg <= '0;
      res_sel_reg <= 1'b0;
    end else begin
      res_valid_reg <= cmd_valid;
      if (cmd_valid) begin
        res_kind_reg <= kind_w;
        res_idx_reg <= use_default ? UIS_IDX_NONE : idx;
        res_uuid_reg <= (kind_w == UIS_RES_SELECT) ? ent : UIS_ZERO_UUID;
        res_sel_reg <= cmd_sel;
      end
    end
  end

  // list readback, entry zero and past-end entries read as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      rd_valid_reg <= rd_req;
      if (rd_req) begin
        rd_data_reg <= (term_seen[rd_idx] || rd_idx == UIS_IDX_NONE) ?
                       UIS_ZERO_UUID : list_mem[rd_idx];
      end
    end
  end

  // activation scan registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fw_state_reg <= UIS_FW_IDLE;
      fw_idx_reg <= UIS_IDX_FIRST;
      fw_done_reg <= 1'b0;
      fw_reset_reg <= 1'b0;
    end else begin
      fw_state_reg <= fw_state_next;
      fw_done_reg <= (fw_state_reg == UIS_FW_DONE);
      if (fw_state_reg == UIS_FW_IDLE && fw_start) begin
        fw_idx_reg <= UIS_IDX_FIRST;
        fw_reset_reg <= major_diff;
      end else if (fw_state_reg == UIS_FW_SCAN) begin
        fw_idx_reg <= fw_idx_reg + 7'h01;
        if (fw_conflict) begin
          fw_reset_reg <= 1'b1;
        end
      end
    end
  end

  // outputs from flip-flops
  assign res_valid = res_valid_reg;
  assign res_kind = res_kind_reg;
  assign res_idx = res_idx_reg;
  assign res_uuid = res_uuid_reg;
  assign res_sel_sup = res_sel_reg;
  assign controller_attribute_flags = attr_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign fw_scan_idx = fw_idx_reg;
  assign fw_done = fw_done_reg;
  assign fw_reset_req = fw_reset_reg;
endmodule : uis_top

// *** uis_chk.sv ***
// Purpose: port assertions for the uuid index selector
// Assumes: one clock mclk, async reset rst
// Notes: bound into uis_top after the module
`timescale 1ns/1ps
module uis_chk
  import uis_pkg::*;
#(
  parameter logic [UIS_UUID_W-1:0] INVALID_MARKER = 128'h1
)
(
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic cmd_valid, // command
  input wire logic [31:0] cmd_dw, // index dword
  input wire logic sel_wr, // support write
  input wire logic sel_wr_en, // support value
  input wire logic fw_start, // check start
  input wire logic [UIS_REV_W-1:0] fw_major_old, // old rev
  input wire logic [UIS_REV_W-1:0] fw_major_new, // new rev
  input wire logic res_valid, // outcome
  input wire logic [1:0] res_kind, // kind
  input wire logic [UIS_IDX_W-1:0] res_idx, // index
  input wire logic [UIS_UUID_W-1:0] res_uuid, // id
  input wire logic res_sel_sup, // support
  input wire logic [31:0] controller_attribute_flags, // flags
  input wire logic fw_done, // check done
  input wire logic fw_reset_req // reset needed
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // command naming no entry
  sequence zero_cmd_s;
    cmd_valid && cmd_dw[6:0] == UIS_IDX_NONE;
  endsequence
  // activation across major revisions, then its verdict
  sequence major_chg_s;
    fw_start && fw_major_old != fw_major_new;
  endsequence
  sequence reset_done_s;
    fw_reset_req ##1 fw_done;
  endsequence
  // outcome timing and fields
  res_pulse_a: assert property (cmd_valid |=> res_valid)
    else $error("no outcome pulse");
  idx_echo_a: assert property (
    res_valid |-> res_idx == ((res_kind == UIS_RES_DEFAULT) ?
    UIS_IDX_NONE : $past(cmd_dw[6:0])))
    else $error("index not carried");
  zero_dflt_a: assert property (zero_cmd_s |=> res_kind == UIS_RES_DEFAULT)
    else $error("zero index not default");
  nosel_dflt_a: assert property (
    res_valid && !res_sel_sup |-> res_kind == UIS_RES_DEFAULT)
    else $error("unsupported command selected");
  sel_uuid_a: assert property (
    res_valid && res_kind == UIS_RES_SELECT |->
    res_uuid != UIS_ZERO_UUID && res_uuid != INVALID_MARKER)
    else $error("selected empty or marker");
  abort_uuid_a: assert property (
    res_valid && res_kind != UIS_RES_SELECT |-> res_uuid == UIS_ZERO_UUID)
    else $error("id on non-select");
  attr_set_a: assert property (
    sel_wr && sel_wr_en |=> ##1
    controller_attribute_flags[UIS_ATTR_UUID_LIST_BIT])
    else $error("list flag not set");
  major_rst_a: assert property (major_chg_s |=> reset_done_s)
    else $error("major change no reset");
endmodule : uis_chk

bind uis_top uis_chk #(.INVALID_MARKER(INVALID_MARKER)) i_chk (.mclk, .rst,
  .cmd_valid, .cmd_dw, .sel_wr, .sel_wr_en, .fw_start, .fw_major_old,
  .fw_major_new, .res_valid, .res_kind, .res_idx, .res_uuid, .res_sel_sup,
  .controller_attribute_flags, .fw_done, .fw_reset_req);

// *** uis_host.sv ***
// Purpose: host model issuing commands and holding a new image list
// Assumes: called just after a rising edge
// Notes: index dword scrambled once released, opcode left as is
`timescale 1ns/1ps
module uis_host
  import uis_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic [UIS_IDX_W-1:0] fw_scan_idx, // entry wanted
  output logic cmd_valid = 1'b0, // command strobe
  output logic [UIS_CMD_W-1:0] cmd_op = 8'h00, // opcode
  output logic [31:0] cmd_dw = 32'h0, // index dword
  output logic [UIS_UUID_W-1:0] fw_new_entry // image entry
);
  logic [UIS_UUID_W-1:0] img [UIS_DEPTH] = '{default: UIS_ZERO_UUID};
  // image entry answers the scan index at once
  assign fw_new_entry = img[fw_scan_idx];
  // one command held up to its taking edge
  task issue(input logic [7:0] op, input logic [6:0] idx);
    cmd_op = op;
    cmd_dw = {25'h0, idx};
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_dw = ~cmd_dw;
  endtask : issue
endmodule : uis_host

// *** uuid_index_selector_tb.sv ***
// Purpose: self-checking bench for the uuid index selector
// Assumes: host model drives commands and the new image
// Notes: whole list written before any command
`timescale 1ns/1ps
module uuid_index_selector_tb;
  import uis_pkg::*;
  localparam logic [127:0] ID_A = 128'hA1;
  localparam logic [127:0] ID_B = 128'hB2;
  localparam logic [127:0] MRK = 128'h1;
  localparam logic [127:0] LST [5] = '{128'h0, ID_A, ID_B, MRK, 128'hC3};
  localparam logic [6:0] IX [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
    7'h05, 7'h09, 7'h01};
  localparam logic [1:0] KD [8] = '{UIS_RES_DEFAULT, UIS_RES_SELECT,
    UIS_RES_SELECT, UIS_RES_ABORT, UIS_RES_ABORT, UIS_RES_ABORT,
    UIS_RES_ABORT, UIS_RES_DEFAULT};
  localparam logic [127:0] UU [8] = '{128'h0, ID_A, ID_B, 128'h0, 128'h0,
    128'h0, 128'h0, 128'h0};
  logic mclk = 1'b0, rst = 1'b1, list_wr = 1'b0, sel_wr = 1'b0;
  logic sel_wr_en = 1'b0, sup_wr = 1'b0, rd_req = 1'b0, fw_start = 1'b0;
  logic [6:0] list_wr_idx = 7'h0, sup_wr_idx = 7'h0, rd_idx = 7'h0;
  logic [7:0] sel_wr_cmd = 8'h0, fw_major_old = 8'h0, fw_major_new = 8'h0;
  logic [127:0] list_wr_data = 128'h0, fw_new_entry, res_uuid, rd_data;
  logic [255:0] sup_wr_mask = 256'h0;
  logic [31:0] cmd_dw, controller_attribute_flags;
  logic [7:0] cmd_op;
  logic [6:0] res_idx, fw_scan_idx;
  logic [1:0] res_kind;
  logic cmd_valid, res_valid, res_sel_sup, rd_valid, fw_done, fw_reset_req;
  int mismatches, total_checks;
  uis_host i_host (.mclk, .fw_scan_idx, .cmd_valid, .cmd_op, .cmd_dw,
    .fw_new_entry);
  uis_top #(.INVALID_MARKER(MRK)) i_dut (.mclk, .rst, .list_wr, .list_wr_idx,
    .list_wr_data, .sel_wr, .sel_wr_cmd, .sel_wr_en, .sup_wr, .sup_wr_idx,
    .sup_wr_mask, .cmd_valid, .cmd_op, .cmd_dw, .rd_req, .rd_idx, .fw_start,
    .fw_major_old, .fw_major_new, .fw_new_entry, .res_valid, .res_kind,
    .res_idx, .res_uuid, .res_sel_sup, .controller_attribute_flags,
    .rd_valid, .rd_data, .fw_scan_idx, .fw_done, .fw_reset_req);
  // count a comparison, report a miss
  task ck(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : ck
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task rd_chk(input logic [6:0] i, input logic [127:0] want);
    rd_req = 1'b1;
    rd_idx = i;
    step(1);
    rd_req = 1'b0;
    ck(rd_valid === 1'b1 && rd_data === want, "list read");
    step(1);
  endtask : rd_chk
  // support bit for opcode 2, then list filled and read back
  task t_setup;
    ck(controller_attribute_flags[9] === 1'b0, "flag at reset");
    {sel_wr, sel_wr_cmd, sel_wr_en} = {1'b1, 8'h02, 1'b1};
    step(1);
    sel_wr = 1'b0;
    step(2);
    ck(controller_attribute_flags[9] === 1'b1, "flag not set");
    {list_wr, sup_wr} = 2'h3;
    for (int k = 1; k < UIS_DEPTH; k++) begin
      {list_wr_idx, sup_wr_idx} = {7'(k), 7'(k)};
      // stray supported id at 9 sits past the terminator at 5
      list_wr_data = k < 5 ? LST[k] : (k == 9 ? ID_A : UIS_ZERO_UUID);
      sup_wr_mask = (k < 4 || k == 9) ? 256'h4 : 256'h0;
      step(1);
    end
    {list_wr, sup_wr} = 2'h0;
    rd_chk(7'h0, UIS_ZERO_UUID);
    rd_chk(7'h2, ID_B);
    rd_chk(7'h7, UIS_ZERO_UUID);
    rd_chk(7'h9, UIS_ZERO_UUID);
  endtask : t_setup
  // default, two selects, three aborts, past end, unsupported opcode
  task t_cmds;
    for (int r = 0; r < 8; r++) begin
      i_host.issue(r < 7 ? 8'h02 : 8'h03, IX[r]);
      ck(res_valid === 1'b1 && res_sel_sup === (r < 7), "pulse");
      ck(res_kind === KD[r], "kind");
      ck(res_uuid === UU[r], "id");
      ck(res_idx === (r < 7 ? IX[r] : UIS_IDX_NONE), "index");
      step(1);
    end
  endtask : t_cmds
  // support withdrawn: flag drops and selection stops
  task t_clear;
    {sel_wr, sel_wr_cmd, sel_wr_en} = {1'b1, 8'h02, 1'b0};
    step(1);
    sel_wr = 1'b0;
    step(2);
    ck(controller_attribute_flags[9] === 1'b0, "flag kept");
    i_host.issue(8'h02, 7'h01);
    ck(res_valid === 1'b1 && res_sel_sup === 1'b0, "sel kept");
    ck(res_kind === UIS_RES_DEFAULT, "not default");
    ck(res_uuid === UIS_ZERO_UUID && res_idx === 7'h00, "fields");
    step(1);
  endtask : t_clear
  task fw_run(input logic [7:0] mn, input logic want);
    int n;
    n = 0;
    {fw_major_old, fw_major_new, fw_start} = {8'h03, mn, 1'b1};
    step(1);
    fw_start = 1'b0;
    ck(fw_scan_idx === 7'h01, "scan start");
    while (fw_done !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    ck(fw_done === 1'b1 && fw_reset_req === want, "activation");
    step(1);
  endtask : fw_run
  // major change, append plus withdraw, revived marker
  task t_fw;
    fw_run(8'h04, 1'b1);
    for (int k = 1; k < 5; k++)
      i_host.img[k] = LST[k];
    {i_host.img[2], i_host.img[5]} = {MRK, ID_B};
    fw_run(8'h03, 1'b0);
    i_host.img[3] = ID_A;
    fw_run(8'h03, 1'b1);
  endtask : t_fw
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial forever #2.5 mclk = ~mclk;
  // watchdog, run needs under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    step(3);
    rst = 1'b0;
    t_setup();
    t_cmds();
    t_clear();
    t_fw();
    complete_run();
  end
endmodule : uuid_index_selector_tb
